// File: rtl/sxe_top.sv
// Serial 8-bit I/O expander: two-wire bus target, four byte registers,
// eight bidirectional port pins and an open-drain change alert.
// Assumes the bus clock is far slower than clock so every bus edge is
// seen after synchronisation; nrst stands for the power-on reset.
`timescale 1ns/10ps
`default_nettype none
`include "sxe_defs.svh"
module sxe_top
  import sxe_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_0,
  input  wire logic       addr_strap_1,
  input  wire logic       addr_strap_2,
  input  wire logic [7:0] port_pins_in,
  output logic      [7:0] port_pins_out,
  output logic      [7:0] port_pins_oe,
  output logic            alert_n_out,
  output logic            alert_n_oe
);

  logic [1:0]   bus_sync;
  logic [10:0]  pin_sync;
  logic         scl;
  logic         sda;
  logic [7:0]   pins;
  logic [2:0]   straps;

  sxe_link_type link;
  sxe_link_type next_link;
  sxe_regs_type rg;
  sxe_regs_type next_rg;
  logic         scl_prev;
  logic         sda_prev;
  logic         next_scl_prev;
  logic         next_sda_prev;
  logic         next_sda_oe;
  logic         next_sda_out;
  logic [7:0]   next_port_pins_oe;
  logic         next_alert_n_oe;
  logic         next_alert_n_out;

  logic         scl_rise;
  logic         scl_fall;
  logic         start_seen;
  logic         stop_seen;
  logic         do_load;
  logic [7:0]   rd_byte;

  sxe_sync #(
    .WIDTH (2)
  ) u_bus_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in ({scl_in, sda_in}),
    .sync_out (bus_sync)
  );

  sxe_sync #(
    .WIDTH (11)
  ) u_pin_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in ({addr_strap_2, addr_strap_1, addr_strap_0, port_pins_in}),
    .sync_out (pin_sync)
  );

  assign scl    = bus_sync[1];
  assign sda    = bus_sync[0];
  assign pins   = pin_sync[7:0];
  assign straps = pin_sync[10:8];

  assign scl_rise   = scl & ~scl_prev;
  assign scl_fall   = ~scl & scl_prev;
  // Start and stop are data edges while the clock stays high
  assign start_seen = scl & scl_prev & sda_prev & ~sda;
  assign stop_seen  = scl & scl_prev & ~sda_prev & sda;

  // Read-back mux; bit n of every register is pin n
  function automatic logic [7:0] read_reg(input sxe_regs_type r,
                                          input logic [1:0]   sel,
                                          input logic [7:0]   lvl);
    case (sel)
      `SXE_SEL_SAMPLE:    read_reg = lvl ^ r.read_invert_mask;
      `SXE_SEL_LATCH:     read_reg = r.pin_drive_latch;
      `SXE_SEL_INVERT:    read_reg = r.read_invert_mask;
      default:            read_reg = r.direction_select;
    endcase
  endfunction : read_reg

  assign rd_byte = read_reg(rg, link.sel, pins);

  always_comb begin
    next_link     = link;
    next_rg       = rg;
    next_sda_oe   = sda_oe;
    next_scl_prev = scl;
    next_sda_prev = sda;
    do_load       = 1'b0;
    if (start_seen) begin
      // A repeated start also lands here, so reads may follow a select write
      next_link.state   = ST_ADDR;
      next_link.bit_cnt = `SXE_CNT_ZERO;
      next_sda_oe       = 1'b0;
    end else if (stop_seen) begin
      next_link.state = ST_IDLE;
      next_sda_oe     = 1'b0;
    end else if (scl_rise) begin
      case (link.state)
        ST_ADDR, ST_CMD, ST_WR: begin
          next_link.shift   = {link.shift[6:0], sda};
          next_link.bit_cnt = link.bit_cnt + `SXE_CNT_ONE;
        end
        ST_RD: begin
          next_link.bit_cnt = link.bit_cnt + `SXE_CNT_ONE;
        end
        ST_ACK_RD: begin
          // Not-acknowledge ends the read; the controller then sends stop
          if (sda) begin
            next_link.state = ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (link.state)
        ST_ADDR: begin
          if (link.bit_cnt == `SXE_BYTE_BITS) begin
            if (link.shift[7:1] == {`SXE_ADDR_HI, straps}) begin
              next_link.rw    = link.shift[0];
              next_link.state = ST_ACK_ADDR;
              next_sda_oe     = 1'b1;
            end else begin
              next_link.state = ST_IDLE;
            end
          end
        end
        ST_CMD: begin
          if (link.bit_cnt == `SXE_BYTE_BITS) begin
            next_link.sel   = link.shift[1:0];
            next_link.state = ST_ACK_CMD;
            next_sda_oe     = 1'b1;
          end
        end
        ST_WR: begin
          if (link.bit_cnt == `SXE_BYTE_BITS) begin
            case (link.sel)
              `SXE_SEL_LATCH:  next_rg.pin_drive_latch  = link.shift;
              `SXE_SEL_INVERT: next_rg.read_invert_mask = link.shift;
              `SXE_SEL_DIRECTION: next_rg.direction_select = link.shift;
              default: begin
              end
            endcase
            next_link.state = ST_ACK_WR;
            next_sda_oe     = 1'b1;
          end
        end
        ST_ACK_ADDR: begin
          if (link.rw) begin
            do_load = 1'b1;
          end else begin
            next_link.state   = ST_CMD;
            next_link.bit_cnt = `SXE_CNT_ZERO;
            next_sda_oe       = 1'b0;
          end
        end
        ST_ACK_CMD, ST_ACK_WR: begin
          // Further bytes keep landing in the same register
          next_link.state   = ST_WR;
          next_link.bit_cnt = `SXE_CNT_ZERO;
          next_sda_oe       = 1'b0;
        end
        ST_RD: begin
          if (link.bit_cnt == `SXE_BYTE_BITS) begin
            next_link.state = ST_ACK_RD;
            next_sda_oe     = 1'b0;
          end else begin
            next_link.shift = {link.shift[6:0], 1'b1};
            next_sda_oe     = ~link.shift[6];
          end
        end
        ST_ACK_RD: begin
          do_load = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (do_load) begin
      // Reads use the last select byte; no select byte in a read
      next_link.shift   = rd_byte;
      next_link.bit_cnt = `SXE_CNT_ZERO;
      next_link.state   = ST_RD;
      next_sda_oe       = ~rd_byte[7];
      if (link.sel == `SXE_SEL_SAMPLE) begin
        // Capturing the levels read is what clears the alert
        next_rg.pin_level_sample = pins;
      end
    end
    // Target only: the line is pulled low, never driven high
    next_sda_out      = 1'b0;
    next_alert_n_out  = 1'b0;
    next_port_pins_oe = ~next_rg.direction_select;
    // Only input pins compare; returning levels drop the alert
    next_alert_n_oe   = |((pins ^ next_rg.pin_level_sample) & next_rg.direction_select);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      link.state            <= ST_IDLE;
      link.bit_cnt          <= `SXE_CNT_ZERO;
      link.shift            <= 8'h00;
      link.rw               <= 1'b0;
      link.sel              <= `SXE_SEL_SAMPLE;
      rg.pin_level_sample   <= `SXE_RST_SAMPLE;
      rg.pin_drive_latch    <= `SXE_RST_LATCH;
      rg.read_invert_mask   <= `SXE_RST_INVERT;
      rg.direction_select   <= `SXE_RST_DIRECTION;
      scl_prev              <= 1'b1;
      sda_prev              <= 1'b1;
      sda_oe                <= 1'b0;
      sda_out               <= 1'b0;
      port_pins_oe          <= ~`SXE_RST_DIRECTION;
      alert_n_oe            <= 1'b0;
      alert_n_out           <= 1'b0;
    end else begin
      link                  <= next_link;
      rg                    <= next_rg;
      scl_prev              <= next_scl_prev;
      sda_prev              <= next_sda_prev;
      sda_oe                <= next_sda_oe;
      sda_out               <= next_sda_out;
      port_pins_oe          <= next_port_pins_oe;
      alert_n_oe            <= next_alert_n_oe;
      alert_n_out           <= next_alert_n_out;
    end
  end

  // Latch drives the pin only where the enable is set
  assign port_pins_out = rg.pin_drive_latch;

endmodule : sxe_top
`default_nettype wire

// File: rtl/sxe_defs.svh
// Constants for the serial 8-bit I/O expander: bus address, register
// selects, reset values and bit counts.
// Assumes it is included by the package and by the design modules.
`ifndef SXE_DEFS_SVH
`define SXE_DEFS_SVH

// Upper four bits of the 7-bit target address; straps fill the low three
`define SXE_ADDR_HI        4'h7
// Register select codes carried in the low two bits of the select byte
`define SXE_SEL_SAMPLE     2'h0
`define SXE_SEL_LATCH      2'h1
`define SXE_SEL_INVERT     2'h2
`define SXE_SEL_DIRECTION  2'h3
// Reset values; a direction bit of one means input
`define SXE_RST_LATCH      8'hFF
`define SXE_RST_INVERT     8'h00
`define SXE_RST_DIRECTION  8'hFF
`define SXE_RST_SAMPLE     8'h00
// Bits in one byte on the wire
`define SXE_BYTE_BITS      4'h8
`define SXE_CNT_ZERO       4'h0
`define SXE_CNT_ONE        4'h1

`endif

// File: rtl/sxe_pkg.sv
// Types shared by the I/O expander design files.
// Assumes sxe_defs.svh is on the include path.
`default_nettype none
`include "sxe_defs.svh"
package sxe_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
    ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } sxe_state_type;

  typedef struct packed {
    sxe_state_type state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shift;
    logic          rw;
    logic [1:0]    sel;
  } sxe_link_type;

  typedef struct packed {
    logic [7:0] pin_level_sample;
    logic [7:0] pin_drive_latch;
    logic [7:0] read_invert_mask;
    logic [7:0] direction_select;
  } sxe_regs_type;

endpackage : sxe_pkg
`default_nettype wire

// File: rtl/sxe_sync.sv
// Two-flop synchroniser for pins that arrive from outside the clock.
// Assumes the inputs are quasi-static relative to the clock period.
`timescale 1ns/10ps
`default_nettype none
module sxe_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : sxe_sync
`default_nettype wire

// File: tb/sxe_properties.sv
// Concurrent checks on the I/O expander top ports.
// Assumes one clock and the async reset nrst; bound to every sxe_top.
`timescale 1ns/10ps
`default_nettype none
module sxe_properties (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] port_pins_in,
  input wire logic [7:0] port_pins_out,
  input wire logic [7:0] port_pins_oe,
  input wire logic       alert_n_out,
  input wire logic       alert_n_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_reset_state: assert property (
    $rose(nrst) |-> port_pins_oe == 8'h00 && port_pins_out == 8'hFF && !sda_oe)
    else $error("pins or bus not in reset state");
  a_ack_low_clk: assert property (
    $rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda pulled outside a low clock phase");
  a_sda_steady: assert property (
    scl_in && $past(scl_in, 3) |-> $stable(sda_oe))
    else $error("sda changed while clock high");
  a_sda_release: assert property (
    $fell(sda_oe) |-> !scl_in)
    else $error("sda released while clock high");
  a_pins_on_bus: assert property (
    $changed(port_pins_oe) || $changed(port_pins_out) |-> !scl_in)
    else $error("pin drive changed outside a bus write");
  // An input pin moved, the direction moved, or reset just cleared the sample
  a_alert_rise: assert property (
    $rose(alert_n_oe) |-> ((port_pins_in ^ $past(port_pins_in, 4)) & ~port_pins_oe) != 0
      || $past(port_pins_oe, 4) != port_pins_oe || !$past(nrst, 4))
    else $error("alert rose without an input change");
  a_alert_fall: assert property (
    $fell(alert_n_oe) |-> (port_pins_in ^ $past(port_pins_in, 4)) != 0
      || $past(port_pins_oe, 4) != port_pins_oe || ($past(scl_in, 5) && !scl_in))
    else $error("alert cleared without read or input return");
  a_drains_low: assert property (
    sda_out == 1'b0 && alert_n_out == 1'b0)
    else $error("open drain value not low");
endmodule : sxe_properties

bind sxe_top sxe_properties chk_u (
  .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .port_pins_in(port_pins_in), .port_pins_out(port_pins_out),
  .port_pins_oe(port_pins_oe), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));
`default_nettype wire

// File: tb/sxe_ctrl_model.sv
// Bus controller model: drives SCL, pulls SDA low, samples SDA.
// Assumes the bench resolves SDA with a pull-up; SCL idles high.
`timescale 1ns/10ps
`default_nettype none
module sxe_ctrl_model (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask : wt
  // Low 8 and high 6 clocks, above the 3-clock minimum per level
  task automatic bit_io(input logic b, output logic r);
    wt(4);
    sda_low = !b;
    wt(4);
    scl = 1'b1;
    wt(6);
    r = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    wt(4);
    sda_low = 1'b1;
    wt(6);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(6);
    sda_low = 1'b0;
    wt(8);
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic ak_in,
                      output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ak_in, ak);
  endtask : xfer
endmodule : sxe_ctrl_model
`default_nettype wire

// File: tb/test_serial_8bit_io_expander.sv
// Self-checking bench for the I/O expander: addressing, registers, alert.
// Assumes sxe_ctrl_model as bus controller and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module test_serial_8bit_io_expander
  import sxe_pkg::*;
;
  logic       clock, nrst, sda_out, sda_oe, al_out, al_oe;
  wire  logic scl, sda_low;
  logic [2:0] strap;
  logic [6:0] adr;
  logic [7:0] ext, p_out, p_oe, got;
  logic [7:0] exp_q[$];
  int         num_errors = 0;
  int         n_tests = 0;
  event       got_ev;
  wire  logic       sda = !(sda_low || sda_oe);
  wire  logic [7:0] pins = (p_oe & p_out) | (~p_oe & ext);

  sxe_top dut_u (.clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_0(strap[0]),
    .addr_strap_1(strap[1]), .addr_strap_2(strap[2]), .port_pins_in(pins),
    .port_pins_out(p_out), .port_pins_oe(p_oe), .alert_n_out(al_out), .alert_n_oe(al_oe));
  sxe_ctrl_model h (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] ex);
    n_tests++;
    if (seen !== ex) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, ex);
    end
  endtask : check
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(got_ev) check(got, exp_q.pop_front());

  task automatic probe(input logic [6:0] a, input logic ex);
    logic [7:0] r;
    logic       k;
    h.start();
    h.xfer({a, 1'b0}, 1'b1, r, k);
    h.stop();
    check({7'h00, k}, {7'h00, ex});
  endtask : probe
  task automatic wr(input logic [1:0] s, input logic [7:0] d, input logic dn);
    logic [7:0] r;
    logic       k0, k1, k2;
    k2 = 1'b0;
    h.start();
    h.xfer({adr, 1'b0}, 1'b1, r, k0);
    h.xfer({6'h00, s}, 1'b1, r, k1);
    if (dn) h.xfer(d, 1'b1, r, k2);
    h.stop();
    check({5'h00, k0, k1, k2}, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] e, input int n);
    logic [7:0] r;
    logic       k;
    h.start();
    h.xfer({adr, 1'b1}, 1'b1, r, k);
    check({7'h00, k}, 8'h00);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e);
      h.xfer(8'hFF, i == n - 1, got, k);
      ->got_ev;
    end
    h.stop();
  endtask : rd
  task automatic al_chk(input logic ex);
    repeat (6) @(negedge clock);
    check({7'h00, al_oe}, {7'h00, ex});
  endtask : al_chk

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #2000000;
    num_errors++;
    wrap_up();
  end
  initial begin
    logic [7:0] d, l, m;
    logic [7:0] rv[4];
    rv = '{8'h00, 8'hFF, 8'h00, 8'hFF};
    nrst = 1'b0;
    strap = 3'h0;
    ext = 8'h00;
    d = 8'($urandom(32'h5CB0218A));
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    check(p_oe, 8'h00);
    check(p_out, 8'hFF);
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      repeat (4) @(negedge clock);
      probe(7'h38 + 7'(s), 1'b0);
      probe(7'h38 + 7'((s + 1) % 8), 1'b1);
    end
    adr = 7'h38 + 7'(strap);
    $display("test addressing done");
    for (int s = 1; s < 4; s++) begin
      wr(2'(s), 8'h00, 1'b0);
      rd(rv[s], 2);
    end
    $display("test reset values done");
    l = 8'($urandom());
    m = 8'($urandom());
    wr(3, d, 1'b1);
    wr(1, l, 1'b1);
    wr(2, m, 1'b1);
    check(p_oe, ~d);
    check(p_out, l);
    rd(m, 1);
    wr(1, 8'h00, 1'b0);
    rd(l, 1);
    wr(3, 8'h00, 1'b0);
    rd(d, 1);
    ext = 8'($urandom());
    wr(0, 8'h00, 1'b0);
    rd(((l & ~d) | (ext & d)) ^ m, 1);
    al_chk(1'b0);
    wr(0, ~ext, 1'b1);
    al_chk(1'b0);
    $display("test registers done");
    wr(3, 8'h0F, 1'b1);
    wr(0, 8'h00, 1'b0);
    rd(((l & 8'hF0) | (ext & 8'h0F)) ^ m, 1);
    ext = ext ^ 8'hF0;
    al_chk(1'b0);
    // Driven pins really move here, so a missing output mask would show
    l = l ^ 8'hF0;
    wr(1, l, 1'b1);
    check(p_out, l);
    wr(0, 8'h00, 1'b0);
    al_chk(1'b0);
    ext = ext ^ 8'h01;
    al_chk(1'b1);
    ext = ext ^ 8'h01;
    al_chk(1'b0);
    ext = ext ^ 8'h08;
    al_chk(1'b1);
    rd(((l & 8'hF0) | (ext & 8'h0F)) ^ m, 1);
    al_chk(1'b0);
    $display("test alert done");
    nrst = 1'b0;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    check(p_oe, 8'h00);
    check(p_out, 8'hFF);
    $display("test second reset done");
    wrap_up();
  end
endmodule : test_serial_8bit_io_expander
`default_nettype wire
